// *** logic/event_state_timer.sv ***
`timescale 1ns/100ps
module event_state_timer
  import event_state_timer_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   combine_counters_in,
  input  wire logic                   clock_source_mode_in,
  input  wire logic [1:0]             clock_input_select_in,
  input  wire logic [4:0]             match_capture_select_in,
  input  wire logic [4:0][31:0]       match_reload_value_in,
  input  wire event_ctrl_t [5:0]      event_control_in,
  input  wire logic [3:0][5:0]        output_set_mask_in,
  input  wire logic [3:0][5:0]        output_clear_mask_in,
  input  wire logic [3:0][1:0]        output_direction_control_in,
  input  wire half_masks_t [1:0]      counter_masks_in,
  input  wire logic [4:0][5:0]        capture_event_mask_in,
  input  wire logic [5:0]             event_int_enable_in,
  input  wire logic                   ctrl_write_in,
  input  wire ctrl_t                  ctrl_in,
  input  wire logic                   state_write_in,
  input  wire logic [4:0]             state_value_in,
  input  wire logic                   output_write_in,
  input  wire logic [3:0]             output_value_in,
  input  wire logic [5:0]             flag_clear_in,
  input  wire logic [3:0]             pins_in,
  output logic [3:0]                  timer_outputs_out,
  output logic                        interrupt_out,
  output logic [4:0]                  state_out,
  output logic [31:0]                 count_out,
  output logic [4:0][31:0]            match_capture_out,
  output logic [5:0]                  event_flags_out,
  output logic [1:0]                  halted_out,
  output logic [1:0]                  stopped_out,
  output logic [1:0]                  counting_down_out
);

  logic [3:0]        pin_meta_r;
  logic [3:0]        pin_sync_r;
  logic [3:0]        pin_prev_r;
  logic [3:0]        out_r;
  logic [3:0]        out_prev_r;
  logic [31:0]       cnt_r;
  logic [4:0][31:0]  match_r;
  logic [1:0]        halt_r;
  logic [1:0]        stop_r;
  logic [1:0]        down_r;
  logic [1:0]        bidir_r;
  logic [7:0]        prescale_r;
  logic [7:0]        pre_r;
  logic [4:0]        state_r;
  logic [5:0]        flags_r;
  logic [5:0]        flags_nxt;
  logic              irq_r;
  logic              tclk;
  logic              count_en;
  logic [1:0]        run_ok;
  logic [5:0]        ev;
  logic [5:0]        io_edge;
  logic [1:0]        lim_ev;
  logic [1:0]        halt_ev;
  logic [1:0]        stop_ev;
  logic [1:0]        start_ev;
  logic [4:0]        state_nxt;
  logic [3:0]        out_nxt;
  logic [1:0]        sw_clear;

  // Pin synchronisers and edge history
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
      pin_prev_r <= 4'h0;
      out_prev_r <= 4'h0;
    end
    else
    begin
      pin_meta_r <= pins_in;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      out_prev_r <= out_r;
    end
  end

  // Timer clock enable and prescaler
  always_comb
  begin
    if (clock_source_mode_in)
      tclk = pin_sync_r[clock_input_select_in] & ~pin_prev_r[clock_input_select_in];
    else
      tclk = 1'b1;
    count_en = tclk & (pre_r == prescale_r);
    run_ok   = ~halt_r & ~stop_r & {2{count_en}};
    sw_clear = ctrl_write_in ? ctrl_in.clear : 2'h0;
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pre_r <= PRE_RESET;
    else if (sw_clear[0] || (lim_ev[0] && !bidir_r[0]) || count_en)
      pre_r <= PRE_RESET;
    else if (tclk && !halt_r[0])
      pre_r <= pre_r + 8'h01;
  end

  // Event evaluation
  always_comb
  begin
    event_ctrl_t c;
    logic [31:0] mv;
    logic        hit;
    logic        mok;
    logic        lvl;
    logic        prv;
    logic        iok;
    logic        hx;
    logic        res;
    c   = '0;
    mv  = '0;
    hit = 1'b0;
    mok = 1'b0;
    lvl = 1'b0;
    prv = 1'b0;
    iok = 1'b0;
    hx  = 1'b0;
    res = 1'b0;
    ev      = 6'h00;
    io_edge = 6'h00;
    for (int e = 0; e < NUM_EVENTS; e++)
    begin
      c  = event_control_in[e];
      hx = combine_counters_in ? 1'b0 : c.upper_half_select;
      mv = (c.match_register_select < 3'(NUM_MATCH)) ? match_r[c.match_register_select] : '0;
      if (combine_counters_in)
        hit = (cnt_r == mv);
      else if (c.upper_half_select)
        hit = (cnt_r[31:16] == mv[31:16]);
      else
        hit = (cnt_r[15:0] == mv[15:0]);
      mok = hit && (c.match_register_select < 3'(NUM_MATCH))
            && !match_capture_select_in[c.match_register_select]
            && run_ok[hx];
      lvl = c.output_or_input_select ? out_r[c.pin_select] : pin_sync_r[c.pin_select];
      prv = c.output_or_input_select ? out_prev_r[c.pin_select] : pin_prev_r[c.pin_select];
      unique case (c.pin_condition)
        COND_LOW:  iok = !lvl;
        COND_RISE: iok = lvl && !prv;
        COND_FALL: iok = !lvl && prv;
        COND_HIGH: iok = lvl;
      endcase
      iok = iok && !halt_r[hx];
      unique case (c.condition_combine)
        COMB_OR:    res = mok || iok;
        COMB_MATCH: res = mok;
        COMB_IO:    res = iok;
        COMB_AND:   res = mok && iok;
      endcase
      ev[e] = res && tclk && (state_r < 5'(NUM_STATES))
              && c.event_state_mask[state_r[0]];
      io_edge[e] = (c.condition_combine == COMB_IO) && !c.output_or_input_select
                   && (c.pin_condition == COND_RISE || c.pin_condition == COND_FALL);
    end
    for (int h = 0; h < 2; h++)
    begin
      hx = combine_counters_in ? 1'b0 : 1'(h);
      lim_ev[h]   = |(ev & counter_masks_in[hx].limit);
      halt_ev[h]  = |(ev & counter_masks_in[hx].halt);
      stop_ev[h]  = |(ev & counter_masks_in[hx].stop);
      start_ev[h] = |(ev & io_edge & counter_masks_in[hx].start);
    end
  end

  // Halt, stop and control fields
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      halt_r     <= HALT_RESET;
      stop_r     <= STOP_RESET;
      bidir_r    <= 2'h0;
      prescale_r <= PRE_RESET;
    end
    else
    begin
      halt_r <= (ctrl_write_in ? ctrl_in.halt : halt_r) | halt_ev;
      stop_r <= ((ctrl_write_in ? ctrl_in.stop : stop_r) & ~start_ev) | stop_ev;
      if (ctrl_write_in)
      begin
        bidir_r    <= ctrl_in.bidir;
        prescale_r <= ctrl_in.prescale;
      end
    end
  end

  // Counter
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_r  <= 32'h0000_0000;
      down_r <= 2'h0;
    end
    else if (combine_counters_in)
    begin
      if (sw_clear[0])
        cnt_r <= 32'h0000_0000;
      else if (lim_ev[0] && !bidir_r[0])
        cnt_r <= 32'h0000_0000;
      else if (lim_ev[0])
      begin
        down_r <= 2'h3;
        if (run_ok[0] && cnt_r != 32'h0)
          cnt_r <= cnt_r - 32'h1;
      end
      else if (run_ok[0])
      begin
        if (!down_r[0])
          cnt_r <= cnt_r + 32'h1;
        else if (cnt_r == 32'h0)
        begin
          down_r <= 2'h0;
          cnt_r  <= 32'h1;
        end
        else
          cnt_r <= cnt_r - 32'h1;
      end
    end
    else
    begin
      for (int h = 0; h < 2; h++)
      begin
        if (sw_clear[h])
          cnt_r[h*HALF_W +: HALF_W] <= 16'h0000;
        else if (lim_ev[h] && !bidir_r[h])
          cnt_r[h*HALF_W +: HALF_W] <= 16'h0000;
        else if (lim_ev[h])
        begin
          down_r[h] <= 1'b1;
          if (run_ok[h] && cnt_r[h*HALF_W +: HALF_W] != 16'h0)
            cnt_r[h*HALF_W +: HALF_W] <= cnt_r[h*HALF_W +: HALF_W] - 16'h1;
        end
        else if (run_ok[h])
        begin
          if (!down_r[h])
            cnt_r[h*HALF_W +: HALF_W] <= cnt_r[h*HALF_W +: HALF_W] + 16'h1;
          else if (cnt_r[h*HALF_W +: HALF_W] == 16'h0)
          begin
            down_r[h] <= 1'b0;
            cnt_r[h*HALF_W +: HALF_W] <= 16'h1;
          end
          else
            cnt_r[h*HALF_W +: HALF_W] <= cnt_r[h*HALF_W +: HALF_W] - 16'h1;
        end
      end
    end
  end

  // Match reload and capture
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      match_r <= '0;
    else
    begin
      for (int m = 0; m < NUM_MATCH; m++)
      begin
        if (match_capture_select_in[m])
        begin
          if (|(ev & capture_event_mask_in[m]))
            match_r[m] <= cnt_r;
        end
        else if (combine_counters_in)
        begin
          if (tclk && (lim_ev[0] || cnt_r == 32'h0))
            match_r[m] <= match_reload_value_in[m];
        end
        else
        begin
          if (tclk && (lim_ev[0] || cnt_r[15:0] == 16'h0))
            match_r[m][15:0] <= match_reload_value_in[m][15:0];
          if (tclk && (lim_ev[1] || cnt_r[31:16] == 16'h0))
            match_r[m][31:16] <= match_reload_value_in[m][31:16];
        end
      end
    end
  end

  // Outputs, state and flags
  always_comb
  begin
    logic s;
    logic k;
    logic sw;
    s  = 1'b0;
    k  = 1'b0;
    sw = 1'b0;
    out_nxt   = out_r;
    state_nxt = state_r;
    for (int n = 0; n < NUM_OUTS; n++)
    begin
      s  = |(ev & output_set_mask_in[n]);
      k  = |(ev & output_clear_mask_in[n]);
      sw = (output_direction_control_in[n] == DIR_LOW && down_r[0])
           || (output_direction_control_in[n] == DIR_HIGH && down_r[1]);
      if (sw ? k : s)
        out_nxt[n] = 1'b1;
      else if (sw ? s : k)
        out_nxt[n] = 1'b0;
    end
    for (int e = 0; e < NUM_EVENTS; e++)
    begin
      if (ev[e])
        state_nxt = event_control_in[e].state_load_select
                    ? event_control_in[e].new_state_value
                    : 5'(state_r + event_control_in[e].new_state_value);
    end
    flags_nxt = (flags_r & ~flag_clear_in) | ev;
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_r   <= 4'h0;
      state_r <= STATE_RESET;
      flags_r <= 6'h00;
      irq_r   <= 1'b0;
    end
    else
    begin
      out_r   <= (output_write_in && |halt_r) ? output_value_in : out_nxt;
      state_r <= (state_write_in && |halt_r) ? state_value_in : state_nxt;
      flags_r <= flags_nxt;
      irq_r   <= |(flags_nxt & event_int_enable_in);
    end
  end

  assign timer_outputs_out = out_r;
  assign interrupt_out     = irq_r;
  assign state_out         = state_r;
  assign count_out         = cnt_r;
  assign match_capture_out = match_r;
  assign event_flags_out   = flags_r;
  assign halted_out        = halt_r;
  assign stopped_out       = stop_r;
  assign counting_down_out = down_r;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_halt_blocks;
    (&halt_r) |-> (ev == 6'h00);
  endproperty
  a_halt_blocks: assert property (p_halt_blocks) else $error("event while halted");

  property p_halt_sticky;
    halt_r[0] && !ctrl_write_in |=> halt_r[0];
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt left without write");

  property p_uni_limit;
    combine_counters_in && lim_ev[0] && !bidir_r[0] && !ctrl_write_in |=> cnt_r == 32'h0;
  endproperty
  a_uni_limit: assert property (p_uni_limit) else $error("limit did not clear");

  property p_bidir_limit;
    lim_ev[0] && bidir_r[0] && !sw_clear[0] |=> down_r[0];
  endproperty
  a_bidir_limit: assert property (p_bidir_limit) else $error("limit did not reverse");

  property p_stop_holds;
    stop_r[0] && !lim_ev[0] && !sw_clear[0]
      |=> $stable(cnt_r[15:0]);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

  property p_start;
    stop_r[0] && start_ev[0] && !stop_ev[0] && !ctrl_write_in |=> !stop_r[0];
  endproperty
  a_start: assert property (p_start) else $error("start event ignored");

  property p_irq;
    |(ev & event_int_enable_in) |=> interrupt_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_locked;
    state_r >= 5'(NUM_STATES) |-> ev == 6'h00;
  endproperty
  a_locked: assert property (p_locked) else $error("event in locked state");

  property p_state_load;
    ev[1] && ev[5:2] == 4'h0 && event_control_in[1].state_load_select && !state_write_in
      |=> state_r == $past(event_control_in[1].new_state_value);
  endproperty
  a_state_load: assert property (p_state_load) else $error("state not loaded");

  property p_capture;
    match_capture_select_in[1] && |(ev & capture_event_mask_in[1])
      |=> match_r[1] == $past(cnt_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

endmodule

// *** logic/event_state_timer_pkg.sv ***
package event_state_timer_pkg;
  localparam int NUM_EVENTS = 6;
  localparam int NUM_MATCH  = 5;
  localparam int NUM_OUTS   = 4;
  localparam int NUM_PINS   = 4;
  localparam int NUM_STATES = 2;
  localparam int HALF_W     = 16;
  localparam int PRE_W      = 8;
  localparam logic [1:0] COMB_OR    = 2'h0;
  localparam logic [1:0] COMB_MATCH = 2'h1;
  localparam logic [1:0] COMB_IO    = 2'h2;
  localparam logic [1:0] COMB_AND   = 2'h3;
  localparam logic [1:0] COND_LOW   = 2'h0;
  localparam logic [1:0] COND_RISE  = 2'h1;
  localparam logic [1:0] COND_FALL  = 2'h2;
  localparam logic [1:0] COND_HIGH  = 2'h3;
  localparam logic [1:0] DIR_INDEP  = 2'h0;
  localparam logic [1:0] DIR_LOW    = 2'h1;
  localparam logic [1:0] DIR_HIGH   = 2'h2;
  localparam logic [4:0] STATE_RESET = 5'h00;
  localparam logic [1:0] HALT_RESET  = 2'h3;
  localparam logic [1:0] STOP_RESET  = 2'h0;
  localparam logic [7:0] PRE_RESET   = 8'h00;
  typedef struct packed {
    logic [1:0] event_state_mask;
    logic [4:0] new_state_value;
    logic       state_load_select;
    logic [1:0] condition_combine;
    logic [1:0] pin_condition;
    logic       output_or_input_select;
    logic [1:0] pin_select;
    logic       upper_half_select;
    logic [2:0] match_register_select;
  } event_ctrl_t;
  typedef struct packed {
    logic [5:0] limit;
    logic [5:0] halt;
    logic [5:0] stop;
    logic [5:0] start;
  } half_masks_t;
  typedef struct packed {
    logic [1:0] clear;
    logic [1:0] halt;
    logic [1:0] stop;
    logic [1:0] bidir;
    logic [7:0] prescale;
  } ctrl_t;
endpackage

// *** tb/pin_model.sv ***
`timescale 1ns/100ps
module pin_model
(
  input  wire logic       clock_in,
  input  wire logic [3:0] level_in,
  output logic [3:0]      pins_out
);
  initial
    pins_out = 4'h0;
  // Far-side pins move only between timer clock edges
  always @(negedge clock_in)
    pins_out <= level_in;
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench
  import event_state_timer_pkg::*;
;
  logic                 clock_in = 1'b0;
  logic                 reset_n_in = 1'b0;
  logic                 combine_counters_in, clock_source_mode_in, ctrl_write_in;
  logic                 state_write_in, output_write_in;
  logic [1:0]           clock_input_select_in;
  logic [4:0]           match_capture_select_in, state_value_in;
  logic [4:0][31:0]     match_reload_value_in, match_capture_out;
  event_ctrl_t [5:0]    event_control_in;
  logic [3:0][5:0]      output_set_mask_in, output_clear_mask_in;
  logic [3:0][1:0]      output_direction_control_in;
  half_masks_t [1:0]    counter_masks_in;
  logic [4:0][5:0]      capture_event_mask_in;
  logic [5:0]           event_int_enable_in, flag_clear_in, event_flags_out;
  ctrl_t                ctrl_in;
  logic [3:0]           output_value_in, pin_level, pins_in, timer_outputs_out;
  logic                 interrupt_out;
  logic [4:0]           state_out;
  logic [31:0]          count_out, c1, mx;
  logic [1:0]           halted_out, stopped_out, counting_down_out;
  int                   err_count = 0;
  int                   n_checks = 0;

  always #10 clock_in = ~clock_in;

  pin_model pin_model_inst (.clock_in, .level_in(pin_level), .pins_out(pins_in));

  event_state_timer event_state_timer_inst (
    .clock_in, .reset_n_in, .combine_counters_in, .clock_source_mode_in,
    .clock_input_select_in, .match_capture_select_in, .match_reload_value_in,
    .event_control_in, .output_set_mask_in, .output_clear_mask_in,
    .output_direction_control_in, .counter_masks_in, .capture_event_mask_in,
    .event_int_enable_in, .ctrl_write_in, .ctrl_in, .state_write_in, .state_value_in,
    .output_write_in, .output_value_in, .flag_clear_in, .pins_in, .timer_outputs_out,
    .interrupt_out, .state_out, .count_out, .match_capture_out, .event_flags_out,
    .halted_out, .stopped_out, .counting_down_out);

  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait: sel 0 waits for flag of event 1, sel 1 for down counting
  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    while ((sel == 1 ? counting_down_out[0] : event_flags_out[1]) !== 1'b1 && k < 30)
    begin
      tick(1);
      k++;
    end
    if (k == 30)
    begin
      err_count++;
      $display("MISMATCH wait %0d: expected 1 seen 0", sel);
      final_report();
    end
  endtask

  task automatic wr_ctrl(input logic [1:0] h, input logic [1:0] s, input logic c,
                         input logic bd, input logic [7:0] p);
    ctrl_in = '{clear:{c, c}, halt:h, stop:s, bidir:{1'b0, bd}, prescale:p};
    ctrl_write_in = 1'b1;
    tick(1);
    ctrl_write_in = 1'b0;
    tick(1);
  endtask

  task automatic clear_flags();
    flag_clear_in = 6'h3f;
    tick(1);
    flag_clear_in = 6'h00;
    tick(1);
  endtask

  task automatic t_reset();
    check("halted", 32'h3, {30'h0, halted_out});
    check("state", 32'h0, {27'h0, state_out});
    check("count", 32'h0, count_out);
    $display("test reset done");
  endtask

  task automatic t_run();
    wr_ctrl(2'h0, 2'h0, 1'b1, 1'b0, 8'h00);
    tick(3);
    c1 = count_out;
    tick(5);
    check("count step", c1 + 32'h5, count_out);
    wr_ctrl(2'h0, 2'h0, 1'b1, 1'b0, 8'h03);
    tick(2);
    c1 = count_out;
    tick(20);
    check("prescaled step", c1 + 32'h5, count_out);
    $display("test run done");
  endtask

  task automatic t_limit();
    counter_masks_in[0].limit = 6'h01;
    wr_ctrl(2'h0, 2'h0, 1'b1, 1'b0, 8'h00);
    mx = 32'h0;
    repeat (40)
    begin
      tick(1);
      if (count_out > mx)
        mx = count_out;
    end
    check("wrap max", 32'ha, mx);
    check("match reg", 32'ha, match_capture_out[0]);
    check("capture", 32'ha, match_capture_out[1]);
    check("out0 set", 32'h1, {31'h0, timer_outputs_out[0]});
    wr_ctrl(2'h0, 2'h0, 1'b1, 1'b1, 8'h00);
    wait_hi(1);
    c1 = count_out;
    tick(1);
    check("down count", c1 - 32'h1, count_out);
    wr_ctrl(2'h0, 2'h0, 1'b1, 1'b0, 8'h00);
    $display("test limit done");
  endtask

  task automatic t_stop();
    wr_ctrl(2'h0, 2'h1, 1'b0, 1'b0, 8'h00);
    tick(1);
    clear_flags();
    c1 = count_out;
    tick(5);
    check("stopped", c1, count_out);
    pin_level[0] = 1'b1;
    wait_hi(0);
    check("irq", 32'h1, {31'h0, interrupt_out});
    c1 = count_out;
    tick(3);
    check("restarted", 32'h1, {31'h0, count_out != c1});
    clear_flags();
    check("irq cleared", 32'h0, {31'h0, interrupt_out});
    wr_ctrl(2'h0, 2'h1, 1'b0, 1'b0, 8'h00);
    wr_ctrl(2'h0, 2'h0, 1'b0, 1'b0, 8'h00);
    c1 = count_out;
    tick(3);
    check("sw restart", 32'h1, {31'h0, count_out != c1});
    pin_level[0] = 1'b0;
    tick(4);
    $display("test stop done");
  endtask

  task automatic t_state();
    event_control_in[1].new_state_value = 5'h01;
    event_control_in[1].state_load_select = 1'b1;
    pin_level[0] = 1'b1;
    wait_hi(0);
    tick(1);
    check("state load", 32'h1, {27'h0, state_out});
    pin_level[0] = 1'b0;
    tick(4);
    clear_flags();
    pin_level[0] = 1'b1;
    tick(8);
    check("masked ev", 32'h0, {31'h0, event_flags_out[1]});
    state_value_in = 5'h00;
    state_write_in = 1'b1;
    tick(1);
    state_write_in = 1'b0;
    tick(1);
    check("state refused", 32'h1, {27'h0, state_out});
    wr_ctrl(2'h3, 2'h0, 1'b0, 1'b0, 8'h00);
    c1 = count_out;
    tick(4);
    check("halt freeze", c1, count_out);
    state_write_in = 1'b1;
    output_value_in = 4'ha;
    output_write_in = 1'b1;
    tick(1);
    state_write_in = 1'b0;
    output_write_in = 1'b0;
    tick(1);
    check("state write", 32'h0, {27'h0, state_out});
    check("out write", 32'ha, {28'h0, timer_outputs_out});
    state_value_in = 5'h02;
    state_write_in = 1'b1;
    tick(1);
    state_write_in = 1'b0;
    wr_ctrl(2'h0, 2'h0, 1'b1, 1'b0, 8'h00);
    clear_flags();
    pin_level[0] = 1'b0;
    tick(4);
    pin_level[0] = 1'b1;
    tick(30);
    check("locked flags", 32'h0, {26'h0, event_flags_out});
    check("locked state", 32'h2, {27'h0, state_out});
    $display("test state done");
  endtask

  initial
  begin
    combine_counters_in = 1'b1;
    clock_source_mode_in = 1'b0;
    clock_input_select_in = 2'h0;
    ctrl_write_in = 1'b0;
    state_write_in = 1'b0;
    output_write_in = 1'b0;
    state_value_in = 5'h00;
    output_value_in = 4'h0;
    flag_clear_in = 6'h00;
    pin_level = 4'h0;
    ctrl_in = '0;
    match_capture_select_in = 5'h02;
    match_reload_value_in = '0;
    match_reload_value_in[0] = 32'h0000000a;
    event_control_in = '0;
    event_control_in[0].event_state_mask = 2'h1;
    event_control_in[0].condition_combine = COMB_MATCH;
    event_control_in[1].event_state_mask = 2'h1;
    event_control_in[1].condition_combine = COMB_IO;
    event_control_in[1].pin_condition = COND_RISE;
    output_set_mask_in = '0;
    output_set_mask_in[0] = 6'h01;
    output_clear_mask_in = '0;
    output_direction_control_in = '0;
    counter_masks_in = '0;
    counter_masks_in[0].start = 6'h02;
    capture_event_mask_in = '0;
    capture_event_mask_in[1] = 6'h01;
    event_int_enable_in = 6'h02;
    repeat (12) @(posedge clock_in);
    tick(1);
    reset_n_in = 1'b1;
    tick(1);
    t_reset();
    t_run();
    t_limit();
    t_stop();
    t_state();
    final_report();
  end
endmodule
